// ===== design/rmc_cmd_parser.sv
`timescale 1ns/1ps
module rmc_cmd_parser #(
    parameter int unsigned CLKS_PER_BIT = rmc_pkg::CLKS_PER_BIT
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic config_n_i,
    input wire logic rxd_i,
    output logic txd_o,
    input wire logic [7:0] received_signal_strength_i,
    input wire logic [7:0] temperature_i,
    input wire logic [7:0] supply_level_i,
    output logic normal_mode_o,
    output logic sleep_o,
    output logic [7:0] channel_o,
    output logic [7:0] power_o,
    output logic [31:0] dest_addr_o,
    output logic [2:0] radio_test_o
);
    typedef enum logic [3:0] {
        ST_NORMAL = 4'b0000, ST_CMD = 4'b0001, ST_ARG_CH = 4'b0010, ST_ARG_PW = 4'b0011,
        ST_ARG_DEST = 4'b0100, ST_MEM_ADDR = 4'b0101, ST_MEM_DATA = 4'b0110, ST_AT_R = 4'b0111,
        ST_AT_C = 4'b1000, ST_SLEEP = 4'b1001, ST_LIST = 4'b1010, ST_REPLY = 4'b1011,
        ST_PROMPT = 4'b1100
    } rmc_state_e;

    localparam logic [15:0] BIT_LEN = 16'(CLKS_PER_BIT - 1);
    localparam logic [15:0] HALF_LEN = 16'(CLKS_PER_BIT / 2);

    function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // Receiver, 8N1, sampled mid-bit
    logic rx_busy_q, rx_busy_d, rx_valid_q, rx_valid_d;
    logic [15:0] rx_cnt_q, rx_cnt_d;
    logic [3:0] rx_bit_q, rx_bit_d;
    logic [7:0] rx_sh_q, rx_sh_d;

    always_comb begin
        rx_busy_d = rx_busy_q;
        rx_cnt_d = rx_cnt_q;
        rx_bit_d = rx_bit_q;
        rx_sh_d = rx_sh_q;
        rx_valid_d = 1'b0;
        if (!rx_busy_q) begin
            if (!rxd_i) begin
                rx_busy_d = 1'b1;
                rx_cnt_d = HALF_LEN;
                rx_bit_d = 4'h0;
            end
        end else if (rx_cnt_q != 16'h0000) begin
            rx_cnt_d = rx_cnt_q - 16'h0001;
        end else begin
            rx_cnt_d = BIT_LEN;
            rx_bit_d = rx_bit_q + 4'h1;
            if (rx_bit_q == 4'h0) begin
                // A glitch shorter than half a bit is not a start bit
                rx_busy_d = !rxd_i;
            end else if (rx_bit_q == rmc_pkg::LAST_BIT) begin
                rx_busy_d = 1'b0;
                rx_valid_d = rxd_i;
            end else begin
                rx_sh_d = {rxd_i, rx_sh_q[7:1]};
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_busy_q <= 1'b0;
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 8'h00;
            rx_valid_q <= 1'b0;
        end else begin
            rx_busy_q <= rx_busy_d;
            rx_cnt_q <= rx_cnt_d;
            rx_bit_q <= rx_bit_d;
            rx_sh_q <= rx_sh_d;
            rx_valid_q <= rx_valid_d;
        end
    end

    // Transmitter; idle line shifts ones
    logic tx_start;
    logic [7:0] tx_byte;
    logic tx_busy_q, tx_busy_d;
    logic [15:0] tx_cnt_q, tx_cnt_d;
    logic [3:0] tx_bit_q, tx_bit_d;
    logic [9:0] tx_sh_q, tx_sh_d;

    always_comb begin
        tx_busy_d = tx_busy_q;
        tx_cnt_d = tx_cnt_q;
        tx_bit_d = tx_bit_q;
        tx_sh_d = tx_sh_q;
        if (tx_start) begin
            tx_busy_d = 1'b1;
            tx_cnt_d = BIT_LEN;
            tx_bit_d = 4'h0;
            tx_sh_d = {1'b1, tx_byte, 1'b0};
        end else if (tx_busy_q) begin
            if (tx_cnt_q != 16'h0000) begin
                tx_cnt_d = tx_cnt_q - 16'h0001;
            end else begin
                tx_cnt_d = BIT_LEN;
                tx_sh_d = {1'b1, tx_sh_q[9:1]};
                tx_bit_d = tx_bit_q + 4'h1;
                tx_busy_d = tx_bit_q != rmc_pkg::LAST_BIT;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_busy_q <= 1'b0;
            tx_cnt_q <= 16'h0000;
            tx_bit_q <= 4'h0;
            tx_sh_q <= 10'h3FF;
        end else begin
            tx_busy_q <= tx_busy_d;
            tx_cnt_q <= tx_cnt_d;
            tx_bit_q <= tx_bit_d;
            tx_sh_q <= tx_sh_d;
        end
    end

    assign txd_o = tx_sh_q[0];

    // Command interpreter
    rmc_state_e st_q, st_d, ret_q, ret_d;
    logic [7:0] reply_q, reply_d, chan_stage_q, chan_stage_d, pow_stage_q, pow_stage_d;
    logic [7:0] channel_q, channel_d, power_q, power_d;
    logic [31:0] dest_stage_q, dest_stage_d, dest_q, dest_d;
    logic [1:0] dest_idx_q, dest_idx_d;
    logic [4:0] mem_addr_q, mem_addr_d;
    logic mem_addr_ok_q, mem_addr_ok_d;
    logic [2:0] test_q, test_d;
    logic mem_we, mem_restore;
    logic [7:0] mem_rdata, addr_mode;
    logic [7:0] rx_byte;

    assign rx_byte = rx_sh_q;

    always_comb begin
        st_d = st_q;
        ret_d = ret_q;
        reply_d = reply_q;
        chan_stage_d = chan_stage_q;
        pow_stage_d = pow_stage_q;
        channel_d = channel_q;
        power_d = power_q;
        dest_stage_d = dest_stage_q;
        dest_d = dest_q;
        dest_idx_d = dest_idx_q;
        mem_addr_d = mem_addr_q;
        mem_addr_ok_d = mem_addr_ok_q;
        test_d = test_q;
        tx_start = 1'b0;
        tx_byte = rmc_pkg::PROMPT;
        mem_we = 1'b0;
        mem_restore = 1'b0;
        case (st_q)
            ST_NORMAL: begin
                if (!config_n_i) begin
                    st_d = ST_PROMPT;
                    ret_d = ST_CMD;
                end
            end
            ST_PROMPT: begin
                if (!tx_busy_q) begin
                    tx_start = 1'b1;
                    st_d = ret_q;
                end
            end
            ST_REPLY: begin
                if (!tx_busy_q) begin
                    tx_start = 1'b1;
                    tx_byte = reply_q;
                    st_d = ST_PROMPT;
                end
            end
            ST_LIST: begin
                if (!tx_busy_q) begin
                    tx_start = 1'b1;
                    tx_byte = mem_rdata;
                    mem_addr_d = mem_addr_q + 5'h01;
                    st_d = (mem_addr_q == rmc_pkg::LOC_LAST) ? ST_PROMPT : ST_LIST;
                end
            end
            ST_SLEEP: begin
                if (config_n_i) begin
                    st_d = ST_NORMAL;
                end
            end
            default: begin
                if (rx_valid_q) begin
                    st_d = ST_PROMPT;
                    ret_d = ST_CMD;
                    case (st_q)
                        ST_CMD: begin
                            case (rx_byte)
                                rmc_pkg::CMD_CHANNEL: ret_d = ST_ARG_CH;
                                rmc_pkg::CMD_POWER: ret_d = ST_ARG_PW;
                                rmc_pkg::CMD_MEMORY: ret_d = ST_MEM_ADDR;
                                rmc_pkg::CMD_DEST: begin
                                    ret_d = ST_ARG_DEST;
                                    dest_idx_d = (addr_mode == rmc_pkg::AM_FOUR) ? 2'h0 : rmc_pkg::DEST_LAST_FOUR;
                                end
                                rmc_pkg::CMD_SIGNAL: begin
                                    st_d = ST_REPLY;
                                    reply_d = received_signal_strength_i;
                                end
                                rmc_pkg::CMD_TEMP: begin
                                    st_d = ST_REPLY;
                                    reply_d = temperature_i;
                                end
                                rmc_pkg::CMD_SUPPLY: begin
                                    st_d = ST_REPLY;
                                    reply_d = supply_level_i;
                                end
                                rmc_pkg::CMD_EXIT: begin
                                    st_d = ST_NORMAL;
                                    channel_d = chan_stage_q;
                                    power_d = pow_stage_q;
                                    dest_d = dest_stage_q;
                                end
                                rmc_pkg::CMD_SLEEP: st_d = ST_SLEEP;
                                rmc_pkg::CMD_TEST0: begin
                                    st_d = ST_LIST;
                                    mem_addr_d = 5'h00;
                                end
                                rmc_pkg::CHAR_AT: st_d = ST_AT_R;
                                default: begin
                                    if (in_range(rx_byte, rmc_pkg::CMD_TEST0 + 8'h01, rmc_pkg::CMD_TEST4)) begin
                                        test_d = 3'(rx_byte - rmc_pkg::CMD_TEST0);
                                    end
                                end
                            endcase
                        end
                        ST_ARG_CH: begin
                            if (in_range(rx_byte, rmc_pkg::CH_MIN, rmc_pkg::CH_MAX)) begin
                                chan_stage_d = rx_byte;
                            end
                        end
                        ST_ARG_PW: begin
                            if (in_range(rx_byte, rmc_pkg::PW_MIN, rmc_pkg::PW_MAX)) begin
                                pow_stage_d = rx_byte;
                            end
                        end
                        ST_ARG_DEST: begin
                            // byte per prompt, last byte lowest
                            dest_stage_d = (dest_idx_q == rmc_pkg::DEST_LAST_FOUR) && (addr_mode != rmc_pkg::AM_FOUR)
                                ? {dest_stage_q[31:8], rx_byte} : {dest_stage_q[23:0], rx_byte};
                            dest_idx_d = dest_idx_q + 2'h1;
                            if (dest_idx_q != rmc_pkg::DEST_LAST_FOUR) begin
                                ret_d = ST_ARG_DEST;
                            end
                        end
                        ST_MEM_ADDR: begin
                            if (rx_byte != rmc_pkg::MEM_EXIT) begin
                                ret_d = ST_MEM_DATA;
                                mem_addr_d = rx_byte[4:0];
                                mem_addr_ok_d = rx_byte[7:5] == 3'h0;
                            end
                        end
                        ST_MEM_DATA: begin
                            mem_we = mem_addr_ok_q;
                            ret_d = ST_MEM_ADDR;
                        end
                        ST_AT_R: begin
                            if (rx_byte == rmc_pkg::CHAR_R) begin
                                st_d = ST_AT_C;
                            end
                        end
                        ST_AT_C: begin
                            // only while the pin is low
                            mem_restore = (rx_byte == rmc_pkg::CHAR_C) && !config_n_i;
                        end
                        default: ;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= ST_NORMAL;
            ret_q <= ST_CMD;
            reply_q <= 8'h00;
            chan_stage_q <= rmc_pkg::RST_CHANNEL;
            pow_stage_q <= rmc_pkg::RST_POWER;
            channel_q <= rmc_pkg::RST_CHANNEL;
            power_q <= rmc_pkg::RST_POWER;
            dest_stage_q <= rmc_pkg::RST_DEST;
            dest_q <= rmc_pkg::RST_DEST;
            dest_idx_q <= 2'h0;
            mem_addr_q <= 5'h00;
            mem_addr_ok_q <= 1'b0;
            test_q <= rmc_pkg::RT_NORMAL;
        end else begin
            st_q <= st_d;
            ret_q <= ret_d;
            reply_q <= reply_d;
            chan_stage_q <= chan_stage_d;
            pow_stage_q <= pow_stage_d;
            channel_q <= channel_d;
            power_q <= power_d;
            dest_stage_q <= dest_stage_d;
            dest_q <= dest_d;
            dest_idx_q <= dest_idx_d;
            mem_addr_q <= mem_addr_d;
            mem_addr_ok_q <= mem_addr_ok_d;
            test_q <= test_d;
        end
    end

    // Read address is the next value, so read data always matches the current address
    // even on the cycle the list state starts
    rmc_cfg_mem u_mem (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .we_i(mem_we),
        .waddr_i(mem_addr_q),
        .wdata_i(rx_byte),
        .restore_i(mem_restore),
        .raddr_i(mem_addr_d),
        .rdata_o(mem_rdata),
        .addr_mode_o(addr_mode)
    );

    assign normal_mode_o = st_q == ST_NORMAL;
    assign sleep_o = st_q == ST_SLEEP;
    assign channel_o = channel_q;
    assign power_o = power_q;
    assign dest_addr_o = dest_q;
    assign radio_test_o = test_q;

    entry_prompt_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == ST_NORMAL && !config_n_i |=> st_q == ST_PROMPT ##1 tx_busy_q)
        else $error("no prompt after entering command mode");
    prompt_byte_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        tx_start && st_q == ST_PROMPT |=> tx_sh_q == {1'b1, rmc_pkg::PROMPT, 1'b0})
        else $error("prompt byte wrong");
    exit_silent_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rx_valid_q && st_q == ST_CMD && rx_byte == rmc_pkg::CMD_EXIT |=> st_q == ST_NORMAL && !tx_busy_q)
        else $error("exit did not return silently");
    apply_params_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(normal_mode_o) |-> channel_o == chan_stage_q && power_o == pow_stage_q && dest_addr_o == dest_stage_q)
        else $error("staged parameters not applied");
    channel_range_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rx_valid_q && st_q == ST_ARG_CH && !in_range(rx_byte, rmc_pkg::CH_MIN, rmc_pkg::CH_MAX)
        |=> $stable(chan_stage_q))
        else $error("channel out of range taken");
    power_set_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rx_valid_q && st_q == ST_ARG_PW && in_range(rx_byte, rmc_pkg::PW_MIN, rmc_pkg::PW_MAX)
        |=> pow_stage_q == $past(rx_byte))
        else $error("power not staged");
    signal_reply_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rx_valid_q && st_q == ST_CMD && rx_byte == rmc_pkg::CMD_SIGNAL
        |=> st_q == ST_REPLY && reply_q == $past(received_signal_strength_i))
        else $error("signal strength reply wrong");
    mem_leave_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rx_valid_q && st_q == ST_MEM_ADDR && rx_byte == rmc_pkg::MEM_EXIT |=> st_q == ST_PROMPT && ret_q == ST_CMD)
        else $error("memory menu not left");
    sleep_wake_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == ST_SLEEP && config_n_i |=> st_q == ST_NORMAL)
        else $error("sleep did not wake");
    unknown_cmd_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rx_valid_q && st_q == ST_CMD && rx_byte == 8'h00 |=> st_q == ST_PROMPT && ret_q == ST_CMD && $stable(test_q))
        else $error("unknown command not ignored");
endmodule

// ===== design/rmc_pkg.sv
package rmc_pkg;
    // Serial link timing
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned BAUD_RATE = 19200;
    localparam int unsigned CLKS_PER_BIT = CLK_HZ / BAUD_RATE;
    localparam int unsigned BIT_CNT_W = 16;
    localparam logic [3:0] LAST_BIT = 4'h9;

    // Command bytes, same value whether sent as character or binary
    localparam logic [7:0] CMD_CHANNEL = 8'h43;
    localparam logic [7:0] CMD_POWER = 8'h50;
    localparam logic [7:0] CMD_SIGNAL = 8'h53;
    localparam logic [7:0] CMD_DEST = 8'h54;
    localparam logic [7:0] CMD_TEMP = 8'h55;
    localparam logic [7:0] CMD_SUPPLY = 8'h56;
    localparam logic [7:0] CMD_MEMORY = 8'h4D;
    localparam logic [7:0] CMD_EXIT = 8'h58;
    localparam logic [7:0] CMD_SLEEP = 8'h5A;
    localparam logic [7:0] CMD_TEST0 = 8'h30;
    localparam logic [7:0] CMD_TEST4 = 8'h34;
    localparam logic [7:0] CHAR_AT = 8'h40;
    localparam logic [7:0] CHAR_R = 8'h52;
    localparam logic [7:0] CHAR_C = 8'h43;
    localparam logic [7:0] PROMPT = 8'h3E;
    localparam logic [7:0] MEM_EXIT = 8'hFF;

    // Argument ranges
    localparam logic [7:0] CH_MIN = 8'h01;
    localparam logic [7:0] CH_MAX = 8'h12;
    localparam logic [7:0] PW_MIN = 8'h01;
    localparam logic [7:0] PW_MAX = 8'h05;

    // Address width setting
    localparam logic [7:0] AM_NONE = 8'h00;
    localparam logic [7:0] AM_ONE = 8'h02;
    localparam logic [7:0] AM_FOUR = 8'h08;
    localparam logic [1:0] DEST_LAST_FOUR = 2'h3;

    // Parameter memory
    localparam int unsigned MEM_AW = 5;
    localparam int unsigned MEM_DEPTH = 32;
    localparam logic [4:0] LOC_CHANNEL = 5'h00;
    localparam logic [4:0] LOC_POWER = 5'h01;
    localparam logic [4:0] LOC_RATE = 5'h02;
    localparam logic [4:0] LOC_PKT_LEN_L = 5'h0F;
    localparam logic [4:0] LOC_TIMEOUT = 5'h10;
    localparam logic [4:0] LOC_ADDR_MODE = 5'h14;
    localparam logic [4:0] LOC_LAST = 5'h1F;

    // Values after reset
    localparam logic [7:0] RST_CHANNEL = 8'h0D;
    localparam logic [7:0] RST_POWER = 8'h05;
    localparam logic [31:0] RST_DEST = 32'h0000_0000;

    typedef enum logic [2:0] {
        RT_NORMAL = 3'b000,
        RT_CARRIER = 3'b001,
        RT_PN9 = 3'b010,
        RT_RX = 3'b011,
        RT_OFF = 3'b100
    } rmc_test_e;

    function automatic logic [7:0] factory_value(input logic [4:0] loc);
        case (loc)
            LOC_CHANNEL: factory_value = RST_CHANNEL;
            LOC_POWER: factory_value = RST_POWER;
            LOC_RATE: factory_value = 8'h03;
            LOC_PKT_LEN_L: factory_value = 8'h80;
            LOC_TIMEOUT: factory_value = 8'h7C;
            LOC_ADDR_MODE: factory_value = AM_ONE;
            default: factory_value = 8'h00;
        endcase
    endfunction
endpackage

// ===== design/rmc_cfg_mem.sv
`timescale 1ns/1ps
module rmc_cfg_mem (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic we_i,
    input wire logic [4:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic restore_i,
    input wire logic [4:0] raddr_i,
    output logic [7:0] rdata_o,
    output logic [7:0] addr_mode_o
);
    logic [7:0] mem_q [rmc_pkg::MEM_DEPTH];
    logic [7:0] rdata_q;
    logic [7:0] mode_q;

    // Reset stands in for the persistent contents, which a simulation cannot keep
    for (genvar i = 0; i < rmc_pkg::MEM_DEPTH; i++) begin : g_word
        localparam logic [4:0] LOC = 5'(i);
        always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                mem_q[i] <= rmc_pkg::factory_value(LOC);
            end else if (restore_i) begin
                mem_q[i] <= rmc_pkg::factory_value(LOC);
            end else if (we_i && waddr_i == LOC) begin
                mem_q[i] <= wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= 8'h00;
            mode_q <= rmc_pkg::AM_ONE;
        end else begin
            rdata_q <= mem_q[raddr_i];
            mode_q <= mem_q[rmc_pkg::LOC_ADDR_MODE];
        end
    end

    assign rdata_o = rdata_q;
    assign addr_mode_o = mode_q;
endmodule

// ===== verif/rmc_host.sv
`timescale 1ns/1ps
module rmc_host #(
    parameter int B = 16
) (
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o
);
    initial rxd_o = 1'b1;
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd_o <= f[i];
            repeat (B) @(posedge clk_i);
        end
    endtask
    // Next byte only after this returns
    task automatic recv(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        while (txd_i === 1'b1 && n < 40 * B) begin
            @(posedge clk_i);
            n++;
        end
        ok = (txd_i === 1'b0);
        repeat (B / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (B) @(posedge clk_i);
            b[i] = txd_i;
        end
        repeat (B) @(posedge clk_i);
    endtask
endmodule

// ===== verif/radio_module_config_cmd_parser_bench.sv
`timescale 1ns/1ps
module radio_module_config_cmd_parser_bench;
    logic clk_i, nrst_i, config_n_i, rxd, txd, normal_mode, sleep, ok;
    logic [7:0] rss, temp, sup, channel, power, r;
    logic [31:0] dest;
    logic [2:0] radio_test;
    logic [31:0] seed = 32'd31330;
    int error_cnt = 0, comparisons = 0, ch = 8'h0D, pw = 8'h05, ds = 0, a;
    rmc_cmd_parser #(.CLKS_PER_BIT(16)) rmc_cmd_parser_inst (.clk_i(clk_i), .nrst_i(nrst_i),
        .config_n_i(config_n_i), .rxd_i(rxd), .txd_o(txd), .received_signal_strength_i(rss),
        .temperature_i(temp), .supply_level_i(sup), .normal_mode_o(normal_mode), .sleep_o(sleep),
        .channel_o(channel), .power_o(power), .dest_addr_o(dest), .radio_test_o(radio_test));
    rmc_host #(.B(16)) rmc_host_inst (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] b, input logic prompt);
        fork
            rmc_host_inst.send(b);
            rmc_host_inst.recv(r, ok);
        join
        chk(ok, prompt);
        if (prompt) chk(r, 8'h3E);
    endtask
    task automatic query(input logic [7:0] b, input logic [7:0] v);
        fork
            rmc_host_inst.send(b);
            begin
                rmc_host_inst.recv(r, ok);
                chk(r, v);
                rmc_host_inst.recv(r, ok);
                chk(r, 8'h3E);
            end
        join
    endtask
    task automatic enter(input logic release_pin);
        @(posedge clk_i);
        config_n_i <= 1'b0;
        rmc_host_inst.recv(r, ok);
        chk(r, 8'h3E);
        @(posedge clk_i);
        if (release_pin) config_n_i <= 1'b1;
    endtask
    task automatic test_done();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_i);
        error_cnt++;
        test_done();
    end
    initial begin
        nrst_i = 1'b0;
        config_n_i = 1'b1;
        {rss, temp, sup} = 24'h0;
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        chk({channel, power, normal_mode, radio_test}, {rmc_pkg::RST_CHANNEL, rmc_pkg::RST_POWER, 4'h8});
        enter(1'b1);
        for (int i = 0; i < 6; i++) begin
            a = rnd() & 8'h1F;
            cmd(8'h43, 1'b1);
            cmd(a[7:0], 1'b1);
            if (a >= 1 && a <= 8'h12) ch = a;
            a = rnd() & 8'h07;
            cmd(8'h50, 1'b1);
            cmd(a[7:0], 1'b1);
            if (a >= 1 && a <= 5) pw = a;
            chk(channel, rmc_pkg::RST_CHANNEL);
        end
        a = rnd();
        {rss, temp, sup} <= a[23:0];
        @(posedge clk_i);
        query(8'h53, rss);
        query(8'h55, temp);
        query(8'h56, sup);
        cmd(8'h41, 1'b1);
        ds = rnd() & 8'hFF;
        cmd(8'h54, 1'b1);
        cmd(ds[7:0], 1'b1);
        for (int t = 1; t < 5; t++) begin
            cmd(8'h30 + t[7:0], 1'b1);
            chk(radio_test, t);
        end
        cmd(8'h33, 1'b1);
        begin
            cmd(8'h4D, 1'b1);
            cmd(8'h14, 1'b1);
            cmd(8'h08, 1'b1);
            cmd(8'hFF, 1'b1);
        end
        cmd(8'h54, 1'b1);
        for (int k = 0; k < 4; k++) begin
            a = rnd() & 8'hFF;
            cmd(a[7:0], 1'b1);
            ds = (ds << 8) | a;
        end
        cmd(8'h58, 1'b0);
        chk({normal_mode, channel, power, dest}, {1'b1, ch[7:0], pw[7:0], ds});
        enter(1'b0);
        // Restore with pin low, then list memory
        cmd(8'h40, 1'b0);
        cmd(8'h52, 1'b0);
        cmd(8'h43, 1'b1);
        fork
            rmc_host_inst.send(8'h30);
            for (int k = 0; k < 33; k++) begin
                rmc_host_inst.recv(r, ok);
                chk(r, k == 32 ? 8'h3E : k == 0 ? 8'h0D : k == 1 ? 8'h05 : k == 2 ? 8'h03 : k == 15 ? 8'h80 :
                    k == 16 ? 8'h7C : k == 20 ? 8'h02 : 8'h00);
            end
        join
        cmd(8'h5A, 1'b0);
        chk(sleep, 1'b1);
        @(posedge clk_i);
        config_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({sleep, normal_mode}, 2'b01);
        test_done();
    end
endmodule
